// ==== hw/config_nvm_transfer_control.sv ====
// Register side of power-down, staged update and EEPROM store/restore control.
//
// What this block does
// RL1: Power-down bits 2,1,0 stop cleanup loop, synthesis loop, distribution; default 1.
// RL2: Writing 1 to the update bit applies staged settings on the next clock edge.
// RL3: The update bit clears itself after the apply.
// RL4: The engine takes start addresses and byte counts from 23 segment registers.
// RL5: Segment list codes for update and end-of-data are executed, not treated as ranges.
// RL6: The reset segment list covers every register then issues an update.
// RL7: The pending bit reads 1 while a store or restore moves data.
// RL8: Status pin zero shows the pending flag when status control bit 4 is set.
// RL9: The error bit reads 1 when a transfer finds incorrect data.
// RL10: With boot select low, the soft-restore bit restores from EEPROM and self-clears.
// RL11: Write enable defaults to 0, keeping the EEPROM write-protected.
// RL12: The store bit starts buffer-to-EEPROM copy and clears when it finishes.
// RL13: A store request is ignored while write protection is on.
`timescale 1ns/1ns
`include "cfg_nvm_params.svh"
module config_nvm_transfer_control
  import cfg_nvm_pkg::*;
#(
  parameter int SEG_COUNT = `SEG_COUNT,
  parameter int EE_AW     = `EE_ADDR_W
) (
  input  wire logic               CLK,
  input  wire logic               SYS_RST,
  input  wire logic [`ADDR_W-1:0] REG_ADDR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_WR,
  output logic      [7:0]         REG_RDATA,
  output logic                    APPLY_STAGED,
  output logic                    PD_CLEANUP_LOOP,
  output logic                    PD_SYNTHESIS_LOOP,
  output logic                    PD_DISTRIBUTION,
  input  wire logic               BOOT_SELECT,
  input  wire logic               STATUS_OTHER,
  output logic                    STATUS_PIN_ZERO,
  output logic      [`ADDR_W-1:0] BUF_ADDR,
  output logic      [7:0]         BUF_WDATA,
  output logic                    BUF_WE,
  input  wire logic [7:0]         BUF_RDATA,
  output logic      [EE_AW-1:0]   EE_ADDR,
  output logic      [7:0]         EE_WDATA,
  output logic                    EE_REQ,
  output logic                    EE_WE,
  input  wire logic [7:0]         EE_RDATA,
  input  wire logic               EE_ACK
);
  localparam logic [8*SEG_COUNT-1:0] SEG_RST = `SEG_LIST_RST;

  logic [7:0] status_ctl_q;
  logic [2:0] pd_q;
  logic       apply_q;
  logic [7:0] seg_q [SEG_COUNT];
  logic       write_en_q;
  logic       soft_q;
  logic       store_q;
  logic [4:0] seg_idx;
  logic       list_end;
  logic [7:0] seg_byte;
  logic       busy;
  logic       eng_done;
  logic       eng_apply;
  logic       eng_err;
  logic       eng_start;
  logic       apply_set;
  logic [7:0] rd_d;

  // True when the host writes the register at the given offset this cycle.
  function automatic logic wr_at(input logic [`ADDR_W-1:0] off);
    return REG_WR && REG_ADDR == off;
  endfunction

  // At the end of the list the engine sees an end code; a range entry in the last two slots takes that code as an address byte.
  assign seg_byte  = list_end ? `SEG_CODE_END : seg_q[seg_idx];
  // Store takes priority when both commands wait; neither starts mid-transfer.
  assign eng_start = (store_q || soft_q) && !busy;
  assign apply_set = (wr_at(`ADDR_APPLY) && REG_WDATA[0]) || eng_apply;

  assign PD_CLEANUP_LOOP   = pd_q[`BIT_PD_CLEANUP]; // [RL1]
  assign PD_SYNTHESIS_LOOP = pd_q[`BIT_PD_SYNTH];   // [RL1]
  assign PD_DISTRIBUTION   = pd_q[`BIT_PD_DIST];    // [RL1]
  assign APPLY_STAGED      = apply_q;
  assign STATUS_PIN_ZERO   = status_ctl_q[`BIT_STATUS_NVM] ? busy : STATUS_OTHER; // [RL8]

  // Plain read/write configuration registers.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status_ctl_q <= `RST_STATUS_CTL;
      pd_q         <= `RST_POWER_DOWN; // [RL1]
      write_en_q   <= 1'b0;            // [RL11]
    end else begin
      if (wr_at(`ADDR_STATUS_CTL)) begin
        status_ctl_q <= {3'h0, REG_WDATA[4:0]};
      end
      if (wr_at(`ADDR_POWER_DOWN)) begin
        pd_q <= REG_WDATA[2:0]; // [RL1]
      end
      if (wr_at(`ADDR_NVM_CTL1)) begin
        write_en_q <= REG_WDATA[`BIT_WRITE_EN]; // [RL11]
      end
    end
  end

  // The apply bit is a one-cycle pulse: set by the host or the list's update code.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      apply_q <= 1'b0;
    end else begin
      apply_q <= apply_set; // [RL2] [RL3] [RL6]
    end
  end

  // Segment list; its reset image covers the whole map and ends with an update.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        seg_q[i] <= SEG_RST[i*8 +: 8]; // [RL6]
      end
    end else if (REG_WR && REG_ADDR >= `ADDR_SEG_FIRST && REG_ADDR <= `ADDR_SEG_LAST) begin
      seg_q[5'(REG_ADDR - `ADDR_SEG_FIRST)] <= REG_WDATA; // [RL4]
    end
  end

  // Command bits: a new request beats the completion clear in the same cycle.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      soft_q  <= 1'b0;
      store_q <= 1'b0;
    end else begin
      if (wr_at(`ADDR_NVM_CTL1) && REG_WDATA[`BIT_SOFT_RESTORE] && !BOOT_SELECT) begin
        soft_q <= 1'b1; // [RL10]
      end else if (eng_done && !store_q) begin
        soft_q <= 1'b0; // [RL10]
      end
      // Protection is judged by the enable already stored, not one written alongside.
      if (wr_at(`ADDR_NVM_CTL2) && REG_WDATA[0] && write_en_q) begin
        store_q <= 1'b1; // [RL12] [RL13]
      end else if (eng_done) begin
        store_q <= 1'b0; // [RL12]
      end
    end
  end

  // Read data is registered, so it appears one cycle after the address.
  always_comb begin
    rd_d = 8'h00;
    case (REG_ADDR)
      `ADDR_STATUS_CTL: rd_d = status_ctl_q;
      `ADDR_POWER_DOWN: rd_d = {5'h0, pd_q};
      `ADDR_APPLY:      rd_d = {7'h0, apply_q};
      `ADDR_NVM_STATE:  rd_d = {7'h0, busy};    // [RL7]
      `ADDR_NVM_ERROR:  rd_d = {7'h0, eng_err}; // [RL9]
      `ADDR_NVM_CTL1:   rd_d = {6'h0, soft_q, write_en_q};
      `ADDR_NVM_CTL2:   rd_d = {7'h0, store_q};
      default: begin
        if (REG_ADDR >= `ADDR_SEG_FIRST && REG_ADDR <= `ADDR_SEG_LAST) begin
          rd_d = seg_q[5'(REG_ADDR - `ADDR_SEG_FIRST)];
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rd_d;
    end
  end

  nvm_transfer_engine #(
    .SEG_COUNT (SEG_COUNT),
    .EE_AW     (EE_AW)
  ) engine (
    .clk       (CLK),
    .rst       (SYS_RST),
    .start     (eng_start),
    .store_dir (store_q),
    .seg_byte  (seg_byte),
    .seg_idx   (seg_idx),
    .list_end  (list_end),
    .busy      (busy),
    .done      (eng_done),
    .apply_req (eng_apply),
    .err       (eng_err),
    .buf_addr  (BUF_ADDR),
    .buf_wdata (BUF_WDATA),
    .buf_we    (BUF_WE),
    .buf_rdata (BUF_RDATA),
    .ee_addr   (EE_ADDR),
    .ee_wdata  (EE_WDATA),
    .ee_req    (EE_REQ),
    .ee_we     (EE_WE),
    .ee_rdata  (EE_RDATA),
    .ee_ack    (EE_ACK)
  );

  sequence apply_pulse_s;
    APPLY_STAGED ##1 !APPLY_STAGED;
  endsequence

  // Assertions spell out the write decode: a function body would read live values, not sampled ones.
  power_down_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL1]
    REG_WR && REG_ADDR == `ADDR_POWER_DOWN |=>
      {PD_CLEANUP_LOOP, PD_SYNTHESIS_LOOP, PD_DISTRIBUTION} == $past(REG_WDATA[2:0]))
    else $error("power-down outputs do not follow the write");

  apply_self_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL2] [RL3]
    REG_WR && REG_ADDR == `ADDR_APPLY && REG_WDATA[0] ##1 !apply_set |-> apply_pulse_s)
    else $error("update pulse missing or not self-cleared");

  list_update_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL5]
    eng_apply |=> APPLY_STAGED)
    else $error("list update code did not apply staged settings");

  pending_read_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL7]
    REG_ADDR == `ADDR_NVM_STATE |=> REG_RDATA == {7'h0, $past(busy)})
    else $error("pending bit does not show transfer state");

  start_pending_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL7]
    eng_start |=> busy ##1 busy)
    else $error("transfer started without pending flag");

  status_pin_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL8]
    status_ctl_q[`BIT_STATUS_NVM] && busy |-> STATUS_PIN_ZERO)
    else $error("status pin zero misses pending flag");

  soft_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL10]
    REG_WR && REG_ADDR == `ADDR_NVM_CTL1 && BOOT_SELECT && !soft_q |=> !soft_q)
    else $error("soft restore taken with boot select high");

  write_protect_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL11] [RL13]
    !write_en_q && !store_q && !soft_q && !busy |=> !store_q && !busy)
    else $error("store started while write protected");

  store_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [RL12]
    eng_done && store_q && !(REG_WR && REG_ADDR == `ADDR_NVM_CTL2) |=> !store_q && !busy)
    else $error("store bit not cleared at transfer end");
endmodule

// ==== hw/cfg_nvm_params.svh ====
// Register offsets, field positions, reset values and list codes for the NVM transfer control block.
`ifndef CFG_NVM_PARAMS_SVH
`define CFG_NVM_PARAMS_SVH
`define ADDR_W          12
`define ADDR_STATUS_CTL 12'h232
`define ADDR_POWER_DOWN 12'h233
`define ADDR_APPLY      12'h234
`define ADDR_SEG_FIRST  12'ha00
`define ADDR_SEG_LAST   12'ha16
`define ADDR_NVM_STATE  12'hb00
`define ADDR_NVM_ERROR  12'hb01
`define ADDR_NVM_CTL1   12'hb02
`define ADDR_NVM_CTL2   12'hb03
`define SEG_COUNT       23
`define BIT_STATUS_NVM  4
`define BIT_PD_CLEANUP  2
`define BIT_PD_SYNTH    1
`define BIT_PD_DIST     0
`define BIT_SOFT_RESTORE 1
`define BIT_WRITE_EN    0
`define RST_STATUS_CTL  8'h00
`define RST_POWER_DOWN  3'h7
`define EE_ADDR_W       10
`define SEG_CODE_UPDATE 8'h80
`define SEG_CODE_END    8'hff
// Five ranges cover 0x000..0x234, then an update code, then end codes.
`define SEG_LIST_RST {{7{8'hff}}, 8'h80, 8'h00, 8'h02, 8'h34, 8'h80, 8'h01, 8'h7f, \
                      8'h00, 8'h01, 8'h7f, 8'h80, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h7f}
`endif

// ==== hw/cfg_nvm_pkg.sv ====
// Types shared by the NVM transfer control block.
package cfg_nvm_pkg;
  typedef enum logic [3:0] {
    E_IDLE,
    E_FETCH,
    E_ADDR_HI,
    E_ADDR_LO,
    E_MOVE,
    E_WAIT,
    E_PUT,
    E_SUM,
    E_SUM_WAIT
  } eng_state_t;
endpackage

// ==== hw/nvm_transfer_engine.sv ====
// Segment-list walker that moves bytes between the buffer bank and the EEPROM.
`timescale 1ns/1ns
`include "cfg_nvm_params.svh"
module nvm_transfer_engine
  import cfg_nvm_pkg::*;
#(
  parameter int SEG_COUNT = `SEG_COUNT,
  parameter int EE_AW     = `EE_ADDR_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire logic               store_dir,
  input  wire logic [7:0]         seg_byte,
  output logic      [4:0]         seg_idx,
  output logic                    list_end,
  output logic                    busy,
  output logic                    done,
  output logic                    apply_req,
  output logic                    err,
  output logic      [`ADDR_W-1:0] buf_addr,
  output logic      [7:0]         buf_wdata,
  output logic                    buf_we,
  input  wire logic [7:0]         buf_rdata,
  output logic      [EE_AW-1:0]   ee_addr,
  output logic      [7:0]         ee_wdata,
  output logic                    ee_req,
  output logic                    ee_we,
  input  wire logic [7:0]         ee_rdata,
  input  wire logic               ee_ack
);
  eng_state_t         st_q;
  logic [4:0]         idx_q;
  logic [6:0]         cnt_q;
  logic [`ADDR_W-1:0] addr_q;
  logic [7:0]         sum_q;
  logic               dir_q;
  logic               is_end;

  // Bytes with the top bit set are codes; only the update code is not an end.
  assign is_end    = list_end || (seg_byte[7] && seg_byte != `SEG_CODE_UPDATE); // [RL5]
  assign list_end  = idx_q == 5'(SEG_COUNT);
  assign seg_idx   = idx_q;
  assign buf_addr  = addr_q;
  assign busy      = st_q != E_IDLE; // [RL7]
  assign done      = st_q == E_SUM_WAIT && ee_ack;
  assign apply_req = st_q == E_FETCH && !is_end && seg_byte == `SEG_CODE_UPDATE; // [RL5]

  // Walks the list: count byte, address high, address low, then the bytes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= E_IDLE;
      idx_q  <= 5'h0;
      cnt_q  <= 7'h0;
      addr_q <= '0;
      dir_q  <= 1'b0;
    end else begin
      case (st_q)
        E_IDLE: if (start) begin
          idx_q <= 5'h0;
          dir_q <= store_dir;
          st_q  <= E_FETCH;
        end
        E_FETCH: begin
          if (is_end) begin
            st_q <= E_SUM;
          end else if (seg_byte == `SEG_CODE_UPDATE) begin
            idx_q <= idx_q + 5'h1;
          end else begin
            cnt_q <= seg_byte[6:0]; // [RL4]
            idx_q <= idx_q + 5'h1;
            st_q  <= E_ADDR_HI;
          end
        end
        E_ADDR_HI: begin
          addr_q[`ADDR_W-1:8] <= seg_byte[`ADDR_W-9:0]; // [RL4]
          idx_q               <= idx_q + 5'h1;
          st_q                <= E_ADDR_LO;
        end
        E_ADDR_LO: begin
          addr_q[7:0] <= seg_byte;
          idx_q       <= idx_q + 5'h1;
          st_q        <= E_MOVE;
        end
        E_MOVE: st_q <= E_WAIT;
        E_WAIT: if (ee_ack) begin
          st_q <= E_PUT;
        end
        E_PUT: begin
          addr_q <= addr_q + 1'b1;
          cnt_q  <= cnt_q - 7'h1;
          st_q   <= (cnt_q == 7'h0) ? E_FETCH : E_MOVE;
        end
        E_SUM: st_q <= E_SUM_WAIT;
        E_SUM_WAIT: if (ee_ack) begin
          st_q <= E_IDLE;
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end

  // EEPROM request holds until acknowledged; a checksum byte closes every transfer.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ee_req   <= 1'b0;
      ee_we    <= 1'b0;
      ee_wdata <= 8'h00;
      ee_addr  <= '0;
      sum_q    <= 8'h00;
    end else begin
      if (st_q == E_IDLE && start) begin
        ee_addr <= '0;
        sum_q   <= 8'h00;
      end
      if (st_q == E_MOVE || st_q == E_SUM) begin
        ee_req   <= 1'b1;
        ee_we    <= dir_q;
        ee_wdata <= (st_q == E_MOVE) ? buf_rdata : sum_q;
      end else if (ee_ack) begin
        ee_req <= 1'b0;
      end
      if (st_q == E_WAIT && ee_ack) begin
        ee_addr <= ee_addr + 1'b1;
        sum_q   <= sum_q + (dir_q ? ee_wdata : ee_rdata);
      end
    end
  end

  // Restored bytes land in the buffer bank one cycle after the EEPROM answers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_we    <= 1'b0;
      buf_wdata <= 8'h00;
    end else begin
      buf_we <= st_q == E_WAIT && ee_ack && !dir_q;
      if (st_q == E_WAIT && ee_ack) begin
        buf_wdata <= ee_rdata;
      end
    end
  end

  // A checksum mismatch on restore flags bad data until the next transfer starts.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err <= 1'b0;
    end else if (st_q == E_IDLE && start) begin
      err <= 1'b0;
    end else if (done && !dir_q && ee_rdata != sum_q) begin
      err <= 1'b1; // [RL9]
    end
  end

  sequence range_walk_s;
    st_q == E_ADDR_HI ##1 st_q == E_ADDR_LO ##1 st_q == E_MOVE;
  endsequence

  range_decode_a: assert property (@(posedge clk) disable iff (rst) // [RL4]
    st_q == E_FETCH && !is_end && !seg_byte[7] |=> range_walk_s)
    else $error("range entry not decoded as count and address");

  update_code_a: assert property (@(posedge clk) disable iff (rst) // [RL5]
    apply_req |=> st_q == E_FETCH && idx_q == $past(idx_q) + 5'h1)
    else $error("update code not stepped over");

  data_error_a: assert property (@(posedge clk) disable iff (rst) // [RL9]
    done && !dir_q && ee_rdata != sum_q |=> err [*2])
    else $error("checksum mismatch not flagged");
endmodule

// ==== sim/nvm_side_model.sv ====
// EEPROM array and buffer register bank standing beside the transfer control block.
`timescale 1ns/1ns
module nvm_side_model (
  input  wire logic [9:0]  ee_addr,
  input  wire logic        clk,
  input  wire logic [7:0]  ee_wdata,
  input  wire logic        ee_req,
  input  wire logic        ee_we,
  input  wire logic        slow,
  input  wire logic        corrupt,
  output logic      [7:0]  ee_rdata,
  output logic             ee_ack,
  input  wire logic [11:0] buf_addr,
  input  wire logic [7:0]  buf_wdata,
  input  wire logic        buf_we,
  output logic      [7:0]  buf_rdata
);
  logic [7:0] ee [0:1023];
  logic [7:0] bank [0:4095];
  int         wcnt = 0;
  int         wait_q = 0;

  // Bank reads are combinational, since the engine samples them without a request.
  assign buf_rdata = bank[buf_addr];

  // Restored bytes land in the bank.
  always @(posedge clk) begin
    if (buf_we) begin
      bank[buf_addr] <= buf_wdata;
    end
  end

  // One ack per request; slow mode stalls three cycles. The read lines toggle between
  // answers so that a stale byte never looks valid.
  initial begin
    ee_ack = 1'b0;
    ee_rdata = 8'h00;
  end
  always @(posedge clk) begin
    ee_ack <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (!ee_req) begin
      wait_q <= slow ? 3 : 0;
    end else if (!ee_ack && wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (!ee_ack) begin
      ee_ack <= 1'b1;
      if (ee_we) begin
        ee[ee_addr] <= ee_wdata;
        wcnt <= wcnt + 1;
      end else begin
        ee_rdata <= ee[ee_addr] ^ {8{corrupt && ee_addr == 10'h000}};
      end
    end
  end
endmodule

// ==== sim/tb_config_nvm_transfer_control.sv ====
// Self-checking bench for the NVM transfer control block.
`timescale 1ns/1ns
`include "cfg_nvm_params.svh"
module tb_config_nvm_transfer_control;
  localparam logic [183:0] SEG_RST = `SEG_LIST_RST;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        REG_WR = 1'b0;
  logic        BOOT_SELECT = 1'b1;
  logic        STATUS_OTHER = 1'b0;
  logic        slow = 1'b0;
  logic        corrupt = 1'b0;
  logic [11:0] REG_ADDR = 12'h000;
  logic [7:0]  REG_WDATA = 8'h00;
  logic [7:0]  REG_RDATA, BUF_WDATA, BUF_RDATA, EE_WDATA, EE_RDATA, v, r;
  logic        APPLY_STAGED, PD_CLEANUP_LOOP, PD_SYNTHESIS_LOOP, PD_DISTRIBUTION, STATUS_PIN_ZERO;
  logic        BUF_WE, EE_REQ, EE_WE, EE_ACK;
  logic [11:0] BUF_ADDR;
  logic [9:0]  EE_ADDR;
  logic [7:0]  saved [0:4095];
  int          err_count = 0, compares = 0, seed = 60952, apply_cnt = 0, k, a, sum;

  config_nvm_transfer_control config_nvm_transfer_control_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
    .APPLY_STAGED(APPLY_STAGED), .PD_CLEANUP_LOOP(PD_CLEANUP_LOOP), .PD_SYNTHESIS_LOOP(PD_SYNTHESIS_LOOP),
    .PD_DISTRIBUTION(PD_DISTRIBUTION), .BOOT_SELECT(BOOT_SELECT), .STATUS_OTHER(STATUS_OTHER),
    .STATUS_PIN_ZERO(STATUS_PIN_ZERO), .BUF_ADDR(BUF_ADDR), .BUF_WDATA(BUF_WDATA), .BUF_WE(BUF_WE),
    .BUF_RDATA(BUF_RDATA), .EE_ADDR(EE_ADDR), .EE_WDATA(EE_WDATA), .EE_REQ(EE_REQ), .EE_WE(EE_WE),
    .EE_RDATA(EE_RDATA), .EE_ACK(EE_ACK));
  nvm_side_model nvm_side_model_inst (.clk(CLK), .ee_addr(EE_ADDR), .ee_wdata(EE_WDATA), .ee_req(EE_REQ),
    .ee_we(EE_WE), .slow(slow), .corrupt(corrupt), .ee_rdata(EE_RDATA), .ee_ack(EE_ACK),
    .buf_addr(BUF_ADDR), .buf_wdata(BUF_WDATA), .buf_we(BUF_WE), .buf_rdata(BUF_RDATA));

  // Free-running 250 MHz clock.
  initial begin
    forever #2 CLK = ~CLK;
  end

  // Counts apply pulses so each transfer can be checked for its update codes.
  always @(posedge CLK) begin
    if (APPLY_STAGED === 1'b1) begin
      apply_cnt++;
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task end_sim;
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= ad;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address.
  task rd(input logic [11:0] ad, output logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= ad;
    @(posedge CLK);
    #1 d = REG_RDATA;
  endtask

  // Polls bit 0 of a register; running out of reads is a mismatch and ends the run.
  task wait_bit(input logic [11:0] ad, input logic b, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd(ad, r);
      if (r[0] === b) break;
    end
    chk(16'(r[0]), 16'(b));
    if (i == lim) end_sim();
  endtask

  // Starts a store or a restore, then follows the pending flag to its end.
  task run(input logic st);
    if (st) begin
      wr(`ADDR_NVM_CTL1, 8'h01);
      wr(`ADDR_NVM_CTL2, 8'h01);
    end else begin
      wr(`ADDR_NVM_CTL1, 8'h02);
    end
    wait_bit(`ADDR_NVM_STATE, 1'b1, 8);
    chk(16'(STATUS_PIN_ZERO), 16'h0001);
    wait_bit(`ADDR_NVM_STATE, 1'b0, 20000);
    rd(st ? `ADDR_NVM_CTL2 : `ADDR_NVM_CTL1, v);
    chk(16'(v & (st ? 8'h01 : 8'h02)), 16'h0000);
  endtask

  // Main sequence.
  initial begin
    for (int i = 0; i < 4096; i++) nvm_side_model_inst.bank[i] = 8'($random(seed));
    repeat (16) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(`ADDR_POWER_DOWN, v);
    chk(16'(v & 8'h07), 16'h0007);
    chk(16'({PD_CLEANUP_LOOP, PD_SYNTHESIS_LOOP, PD_DISTRIBUTION}), 16'h0007);
    rd(`ADDR_NVM_CTL1, v);
    chk(16'(v), 16'h0000);
    rd(12'h100, v);
    chk(16'(v), 16'h0000);
    wr(`ADDR_NVM_STATE, 8'hff);
    rd(`ADDR_NVM_STATE, v);
    chk(16'(v), 16'h0000);
    for (int i = 0; i < 23; i++) begin
      rd(`ADDR_SEG_FIRST + 12'(i), v);
      chk(16'(v), 16'(SEG_RST[8*i +: 8]));
    end
    $display("Test reset values done at %0t", $time);
    for (int i = 0; i < 4; i++) begin
      k = $random(seed);
      wr(`ADDR_POWER_DOWN, 8'(k));
      rd(`ADDR_POWER_DOWN, v);
      chk(16'(v & 8'h07), 16'(k & 7));
      chk(16'({PD_CLEANUP_LOOP, PD_SYNTHESIS_LOOP, PD_DISTRIBUTION}), 16'(k & 7));
    end
    wr(`ADDR_APPLY, 8'h01);
    #1 chk(16'(APPLY_STAGED), 16'h0001);
    @(posedge CLK);
    #1 chk(16'(APPLY_STAGED), 16'h0000);
    rd(`ADDR_APPLY, v);
    chk(16'(v), 16'h0000);
    $display("Test power down and apply done at %0t", $time);
    for (int i = 0; i < 6; i++) begin
      wr(`ADDR_STATUS_CTL, i[0] ? 8'h10 : 8'h00);
      STATUS_OTHER <= 1'($random(seed));
      @(posedge CLK);
      #1 chk(16'(STATUS_PIN_ZERO), i[0] ? 16'h0000 : 16'(STATUS_OTHER));
    end
    wr(`ADDR_NVM_CTL1, 8'h00);
    k = nvm_side_model_inst.wcnt;
    wr(`ADDR_NVM_CTL2, 8'h01);
    rd(`ADDR_NVM_CTL2, v);
    chk(16'(v), 16'h0000);
    repeat (20) @(posedge CLK);
    chk(16'(nvm_side_model_inst.wcnt - k), 16'h0000);
    $display("Test status pin and protection done at %0t", $time);
    k = nvm_side_model_inst.wcnt;
    run(1'b1);
    sum = 0;
    for (int i = 0; i <= 12'h234; i++) begin
      chk(16'(nvm_side_model_inst.ee[i]), 16'(nvm_side_model_inst.bank[i]));
      sum += nvm_side_model_inst.bank[i];
    end
    chk(16'(nvm_side_model_inst.ee[12'h235]), 16'(sum & 255));
    chk(16'(nvm_side_model_inst.wcnt - k), 16'h0236);
    $display("Test default store done at %0t", $time);
    for (int i = 0; i < 4096; i++) begin
      saved[i] = nvm_side_model_inst.bank[i];
      nvm_side_model_inst.bank[i] = ~saved[i];
    end
    wr(`ADDR_NVM_CTL1, 8'h02);
    rd(`ADDR_NVM_CTL1, v);
    chk(16'(v & 8'h02), 16'h0000);
    @(posedge CLK);
    BOOT_SELECT <= 1'b0;
    a = apply_cnt;
    run(1'b0);
    for (int i = 0; i <= 12'h234; i++) chk(16'(nvm_side_model_inst.bank[i]), 16'(saved[i]));
    chk(16'(apply_cnt - a), 16'h0001);
    rd(`ADDR_NVM_ERROR, v);
    chk(16'(v), 16'h0000);
    corrupt <= 1'b1;
    run(1'b0);
    rd(`ADDR_NVM_ERROR, v);
    chk(16'(v & 8'h01), 16'h0001);
    corrupt <= 1'b0;
    $display("Test restore done at %0t", $time);
    wr(`ADDR_SEG_FIRST, 8'h01);
    wr(`ADDR_SEG_FIRST + 12'h001, 8'h00);
    wr(`ADDR_SEG_FIRST + 12'h002, 8'h10);
    wr(`ADDR_SEG_FIRST + 12'h003, `SEG_CODE_UPDATE);
    wr(`ADDR_SEG_FIRST + 12'h004, `SEG_CODE_END);
    slow <= 1'b1;
    k = nvm_side_model_inst.wcnt;
    a = apply_cnt;
    run(1'b1);
    chk(16'(nvm_side_model_inst.wcnt - k), 16'h0003);
    chk(16'(nvm_side_model_inst.ee[0]), 16'(nvm_side_model_inst.bank[16]));
    chk(16'(nvm_side_model_inst.ee[1]), 16'(nvm_side_model_inst.bank[17]));
    sum = nvm_side_model_inst.bank[16] + nvm_side_model_inst.bank[17];
    chk(16'(nvm_side_model_inst.ee[2]), 16'(sum & 255));
    chk(16'(apply_cnt - a), 16'h0001);
    rd(`ADDR_NVM_ERROR, v);
    chk(16'(v), 16'h0000);
    $display("Test custom segment list done at %0t", $time);
    end_sim();
  end
endmodule
